// ==== shared/thermal_alarm_regs.svh ====
`ifndef THERMAL_ALARM_REGS_SVH
`define THERMAL_ALARM_REGS_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_THIRD_STATUS   8'h0A
`define CMD_FIRST_MASK     8'h0C
`define CMD_MODEL_STATUS   8'h38

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define NUM_CHANNELS       5
`define FLAG_MSB           4
`define TEMP_W             8
`define FIRST_MASK_RESET   5'h19
`define FLAGS_RESET        5'h00
`define MODEL_RESET        4'h0
`define READ_IDLE          8'h00
`define PAD_ZERO3          3'h0
`define PAD_ZERO1          1'h0
`define PIN_RELEASED       1'h1

`endif

// ==== shared/thermal_alarm_pkg.sv ====
`default_nettype none

package thermal_alarm_pkg;

  // One 8-bit byte as seen by the management bus.
  typedef logic [7:0] bus_byte_t;

  // One flag per channel: bit 0 local, bits 1 to 4 remote 1 to 4.
  typedef logic [4:0] chan_flags_t;

  // One flag per remote channel, remote 1 in bit 0.
  typedef logic [3:0] remote_flags_t;

  // Temperature reading or limit, whole degrees.
  typedef logic [7:0] temp_t;

  // Reading plus hysteresis, one bit wider so it cannot wrap.
  typedef logic [8:0] temp_sum_t;

endpackage : thermal_alarm_pkg

`default_nettype wire

// ==== design/thermal_alarm_status_mask.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alarm_regs.svh"

module thermal_alarm_status_mask
  import thermal_alarm_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,

  // Register access from the management bus engine
  input  wire logic [7:0]  cmd_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        rd_en_in,
  output logic      [7:0]  rd_data_out,

  // Conversion results, one byte per channel, local in the low byte
  input  wire logic        conv_valid_in,
  input  wire logic [39:0] reading_in,
  input  wire logic [39:0] first_limit_in,
  input  wire logic [39:0] third_limit_in,
  input  wire logic [7:0]  hysteresis_in,

  // Third-output mask and diode model detection, held elsewhere
  input  wire logic [4:0]  third_mask_in,
  input  wire logic [3:0]  beta_comp_en_in,
  input  wire logic [3:0]  std_transistor_in,

  // Critical-temperature pins
  output logic             crit_output_first_n_out,
  output logic             crit_output_third_n_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  chan_flags_t   third_flags_q;
  chan_flags_t   third_flags_d;
  chan_flags_t   first_flags_q;
  chan_flags_t   first_flags_d;
  chan_flags_t   first_mask_q;
  remote_flags_t model_flags_q;
  bus_byte_t     rd_data_q;
  logic          crit_first_n_q;
  logic          crit_third_n_q;

  // ****************************************************************
  // Per-channel hysteresis comparators
  // ****************************************************************
  // A flag holds its value between the set and clear thresholds. The
  // clear test adds the hysteresis to the reading instead of taking it
  // from the limit, so a small limit never wraps to a huge threshold.
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan
      temp_t     reading;
      temp_t     lim_first;
      temp_t     lim_third;
      temp_sum_t lifted;

      assign reading   = reading_in[ch*`TEMP_W +: `TEMP_W];
      assign lim_first = first_limit_in[ch*`TEMP_W +: `TEMP_W];
      assign lim_third = third_limit_in[ch*`TEMP_W +: `TEMP_W];
      assign lifted    = {1'h0, reading} + {1'h0, hysteresis_in};

      always_comb begin
        third_flags_d[ch] = third_flags_q[ch];
        if (reading >= lim_third) begin
          third_flags_d[ch] = 1'h1;
        end else if (lifted < {1'h0, lim_third}) begin
          third_flags_d[ch] = 1'h0;
        end
      end

      always_comb begin
        first_flags_d[ch] = first_flags_q[ch];
        if (reading >= lim_first) begin
          first_flags_d[ch] = 1'h1;
        end else if (lifted < {1'h0, lim_first}) begin
          first_flags_d[ch] = 1'h0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Request decode
  // ****************************************************************
  // Every strobe is qualified by the clock enable here, so the storage
  // below never acts on a request that arrives while the block is frozen.
  logic mask_wr_hit;
  logic rd_take;
  logic conv_take;

  assign mask_wr_hit = ce_in && wr_en_in && (cmd_in == `CMD_FIRST_MASK);
  assign rd_take     = ce_in && rd_en_in;
  assign conv_take   = ce_in && conv_valid_in;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Third and first flags move only on a finished conversion; reads never touch any flag.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      third_flags_q <= `FLAGS_RESET;
    end else if (conv_take) begin
      third_flags_q <= third_flags_d;
    end
  end

  // The first flags have no readable word here; they only reach the
  // outside through the first pin.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_flags_q <= `FLAGS_RESET;
    end else if (conv_take) begin
      first_flags_q <= first_flags_d;
    end
  end

  // Model mismatch follows the detector continuously.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      model_flags_q <= `MODEL_RESET;
    end else if (ce_in) begin
      model_flags_q <= beta_comp_en_in & std_transistor_in;
    end
  end

  // ****************************************************************
  // First-output mask register
  // ****************************************************************
  // Bits 7 to 5 of a write are dropped, so they always read back zero.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_mask_q <= `FIRST_MASK_RESET;
    end else if (mask_wr_hit) begin
      first_mask_q <= wr_data_in[`FLAG_MSB:0];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Each readable word is built once with its reserved bits at zero,
  // so the read selector below only chooses.
  bus_byte_t third_word;
  bus_byte_t model_word;
  bus_byte_t mask_word;

  assign third_word = {`PAD_ZERO3, third_flags_q};
  assign model_word = {`PAD_ZERO3, model_flags_q, `PAD_ZERO1};
  assign mask_word  = {`PAD_ZERO3, first_mask_q};

  // Unmapped codes answer zero so a stray read is harmless.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_q <= `READ_IDLE;
    end else if (rd_take) begin
      case (cmd_in)
        `CMD_THIRD_STATUS: rd_data_q <= third_word;
        `CMD_MODEL_STATUS: rd_data_q <= model_word;
        `CMD_FIRST_MASK:   rd_data_q <= mask_word;
        default:           rd_data_q <= `READ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Unmasked events
  // ****************************************************************
  // A set mask bit hides its channel; a pin is active while any
  // surviving event remains.
  chan_flags_t first_events;
  chan_flags_t third_events;
  logic        first_active;
  logic        third_active;

  assign first_events = first_flags_q & ~first_mask_q;
  assign third_events = third_flags_q & ~third_mask_in;
  assign first_active = |first_events;
  assign third_active = |third_events;

  // ****************************************************************
  // Critical pins
  // ****************************************************************
  // Registered so the pins never glitch while mask bits change, at the
  // cost of one cycle of lag behind the flags.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crit_first_n_q <= `PIN_RELEASED;
    end else if (ce_in) begin
      crit_first_n_q <= ~first_active;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crit_third_n_q <= `PIN_RELEASED;
    end else if (ce_in) begin
      crit_third_n_q <= ~third_active;
    end
  end

  assign rd_data_out             = rd_data_q;
  assign crit_output_first_n_out = crit_first_n_q;
  assign crit_output_third_n_out = crit_third_n_q;

endmodule : thermal_alarm_status_mask

`default_nettype wire

// ==== tb/thermal_alarm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_checker (
  // Ports of the bound block, all observed only
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic [7:0]  cmd_in,
  input wire logic        wr_en_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic        conv_valid_in,
  input wire logic [39:0] reading_in,
  input wire logic [39:0] third_limit_in,
  input wire logic [4:0]  third_mask_in,
  input wire logic        crit_output_third_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [4:0] mask_q;
  // Shadow of the mask, so a read is judged without looking inside.
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in) mask_q <= 5'h19;
    else if (ce_in && wr_en_in && cmd_in == 8'h0C) mask_q <= wr_data_in[4:0];
  sequence rd_s(c);
    ce_in && rd_en_in && cmd_in == c;
  endsequence
  sequence hit4_s;
    ce_in && conv_valid_in && reading_in[39:32] >= third_limit_in[39:32];
  endsequence
  resv_zero_a: assert property (
    ce_in && rd_en_in |=> rd_data_out[7:5] == 3'h0) else $error("bits 7:5 set");
  unmapped_a: assert property (
    ce_in && rd_en_in && !(cmd_in inside {8'h0A, 8'h0C, 8'h38}) |=>
    rd_data_out == 8'h00) else $error("unmapped read not zero");
  rd_hold_a: assert property (
    !(ce_in && rd_en_in) |=> $stable(rd_data_out)) else $error("read moved");
  mask_rd_a: assert property (
    rd_s(8'h0C) |=> rd_data_out[4:0] == $past(mask_q)) else $error("mask read");
  set_four_a: assert property (
    hit4_s ##1 (!conv_valid_in throughout ##[0:8] rd_s(8'h0A)) |=>
    rd_data_out[4]) else $error("status bit 4 not set");
  third_pin_a: assert property (
    hit4_s ##1 (ce_in && !third_mask_in[4]) |=> !crit_output_third_n_out)
    else $error("third pin not driven");
  third_rel_a: assert property (
    ce_in && third_mask_in == 5'h1F |=> crit_output_third_n_out)
    else $error("third pin driven while all masked");
  third_hold_a: assert property (
    !conv_valid_in ##1 (!conv_valid_in && $stable(third_mask_in)) |=>
    $stable(crit_output_third_n_out)) else $error("third pin moved");
endmodule : thermal_alarm_checker
bind thermal_alarm_status_mask thermal_alarm_checker i_thermal_alarm_checker (
  .ref_clk_in, .rstn_in, .ce_in, .cmd_in, .wr_en_in, .wr_data_in, .rd_en_in,
  .rd_data_out, .conv_valid_in, .reading_in, .third_limit_in, .third_mask_in,
  .crit_output_third_n_out);
`default_nettype wire

// ==== tb/smbus_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // Clock
  input  wire logic       clk_in,
  // Register requests towards the block
  output logic      [7:0] cmd_out,
  output logic            wr_en_out,
  output logic      [7:0] wr_data_out,
  output logic            rd_en_out
);
  initial {cmd_out, wr_en_out, wr_data_out, rd_en_out} = '0;
  // Lines are inverted after release so a stale byte is never mistaken.
  task automatic xfer(input logic wr, input logic [7:0] c, d);
    @(negedge clk_in) {cmd_out, wr_en_out} = {c, wr};
    {rd_en_out, wr_data_out} = {!wr, d};
    @(negedge clk_in) {cmd_out, wr_en_out} = {~c, 1'h0};
    {rd_en_out, wr_data_out} = {1'h0, ~d};
  endtask : xfer
endmodule : smbus_host_model
`default_nettype wire

// ==== tb/test_thermal_alarm_status_mask.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_thermal_alarm_status_mask;
  import thermal_alarm_pkg::*;
  logic ref_clk = 1'h0, rstn = 1'h0, conv = 1'h0, ce = 1'h1;
  logic rd_en, wr_en, pin1, pin3;
  logic [7:0] cmd, wr_data, rd_data, hyst = '0;
  logic [39:0] rdg = '0, lim1 = '0, lim3 = '0;
  logic [4:0] tm = '0, tf = '0, ff = '0, mask = 5'h19;
  logic [3:0] beta = '0, stdt = '0;
  logic [31:0] seed = 32'h43;
  bus_byte_t exp_q[$];
  int n_fail = 0, samples_checked = 0, cyc = 0;
  initial forever #50 ref_clk = ~ref_clk;
  smbus_host_model i_smbus_host_model (.clk_in(ref_clk), .cmd_out(cmd),
    .wr_en_out(wr_en), .wr_data_out(wr_data), .rd_en_out(rd_en));
  thermal_alarm_status_mask i_thermal_alarm_status_mask (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .ce_in(ce), .cmd_in(cmd),
    .wr_en_in(wr_en), .wr_data_in(wr_data), .rd_en_in(rd_en),
    .rd_data_out(rd_data), .conv_valid_in(conv), .reading_in(rdg),
    .first_limit_in(lim1), .third_limit_in(lim3), .hysteresis_in(hyst),
    .third_mask_in(tm), .beta_comp_en_in(beta), .std_transistor_in(stdt),
    .crit_output_first_n_out(pin1), .crit_output_third_n_out(pin3));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Flags hold inside the hysteresis band, so the old value is carried in.
  function automatic logic [4:0] upd(logic [4:0] f, logic [39:0] l);
    for (int k = 0; k < 40; k += 8) begin
      if (rdg[k+:8] >= l[k+:8]) f[k/8] = 1'h1;
      else if ({1'h0, rdg[k+:8]} + hyst < {1'h0, l[k+:8]}) f[k/8] = 1'h0;
    end
    return f;
  endfunction : upd
  task automatic cmp(string what, bus_byte_t e, bus_byte_t s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : cmp
  task automatic cmp_pin(string what, logic e, logic s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : cmp_pin
  task automatic print_verdict();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (rd_en === 1'h1) begin
      @(negedge ref_clk) cmp("rd_data", exp_q.pop_front(), rd_data);
    end
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Conversions, register traffic and pin checks
  // ****************************************************************
  initial begin
    logic [31:0] r;
    bus_byte_t rc[5];
    rc = '{8'h0C, 8'h0A, 8'h0A, 8'h38, 8'h08};
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1'h1;
    cmp_pin("pin1", 1'h1, pin1);
    cmp_pin("pin3", 1'h1, pin3);
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      for (int k = 0; k < 40; k += 8) begin
        r = xs();
        rdg[k+:8] = 8'h78 + 8'(r[3:0]);
        lim1[k+:8] = 8'h7C + 8'(r[5:4]);
        lim3[k+:8] = 8'h7C + 8'(r[7:6]);
      end
      r = xs();
      hyst = 8'(r[2:0]);
      tm = (i == 1) ? 5'h1F : r[7:3];
      {beta, stdt} = r[15:8];
      conv = 1'h1;
      // Now and then the enable drops under a conversion, which must then
      // leave every flag as it was.
      ce = r[25] | r[26];
      if (ce) begin
        tf = upd(tf, lim3);
        ff = upd(ff, lim1);
      end
      @(negedge ref_clk) conv = 1'h0;
      ce = 1'h1;
      i_smbus_host_model.xfer(1'h1, r[24] ? 8'h0C : 8'h0A, r[23:16]);
      if (r[24]) mask = r[20:16];
      foreach (rc[j]) begin
        exp_q.push_back(j == 0 ? {3'h0, mask} : j < 3 ? {3'h0, tf} : j == 3 ?
          {3'h0, beta & stdt, 1'h0} : 8'h00);
        i_smbus_host_model.xfer(1'h0, rc[j], 8'h00);
      end
      cmp_pin("pin3", ~|(tf & ~tm), pin3);
      cmp_pin("pin1", ~|(ff & ~mask), pin1);
    end
    print_verdict();
  end
endmodule : test_thermal_alarm_status_mask
`default_nettype wire
